// File: sd_xfer_pkg.sv
// Package of offsets, fields and states for the transfer status block
package sd_xfer_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [4:0] OFS_PRESENT = 5'h00;
	localparam logic [4:0] OFS_GAP_CTRL = 5'h04;
	localparam logic [4:0] OFS_NORM_STAT = 5'h08;
	localparam logic [4:0] OFS_NORM_STEN = 5'h0C;
	localparam logic [4:0] OFS_NORM_SIGEN = 5'h10;
	localparam logic [4:0] OFS_ERR_STAT = 5'h14;
	localparam logic [4:0] OFS_ERR_STEN = 5'h18;
	localparam logic [4:0] OFS_ERR_SIGEN = 5'h1C;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PS_DAT_ACT = 0;
	localparam int PS_WR_ACT = 1;
	localparam int PS_RD_ACT = 2;
	localparam int PS_RD_WAIT = 3;
	localparam int PS_CLK_STOP = 4;
	localparam int GC_STOP = 0;
	localparam int GC_CONT = 1;
	localparam int GC_RWAIT_EN = 2;
	localparam int NS_XFER_DONE = 0;
	localparam int NS_GAP_EVT = 1;
	localparam int ERR_BITS = 10;
	localparam int ES_CMD_TIMEOUT = 0;
	localparam int ES_CMD_CHECKSUM = 1;
	localparam int ES_CMD_ENDBIT = 2;
	localparam int ES_CMD_INDEX = 3;
	localparam int ES_DATA_TIMEOUT = 4;
	localparam int ES_DATA_CHECKSUM = 5;
	localparam int ES_DATA_ENDBIT = 6;
	localparam int ES_CURRENT_LIMIT = 7;
	localparam int ES_AUTO_CMD = 8;
	localparam int ES_DESC_DMA = 9;
	// ----------------------------------------
	// Reset values and timing counts
	// ----------------------------------------
	localparam logic [2:0] GAP_CTRL_RST = 3'h0;
	localparam logic [1:0] NORM_EN_RST = 2'h0;
	localparam logic [9:0] ERR_EN_RST = 10'h000;
	localparam logic [3:0] BUSY_WAIT_SDCLK = 4'h8;
	// ----------------------------------------
	// Write and busy tracker states
	// ----------------------------------------
	typedef enum logic [1:0] {W_IDLE, W_XFER, W_WAIT, W_BUSY} wstate_t;
endpackage : sd_xfer_pkg

// File: sd_xfer_status.sv
// Transfer activity tracking, read stop at gap and error status enables
// Summary of operation
// - Read stopped at gap pauses by read wait on data line two or clock stop.
// - Read wait already held for a full buffer stays held while paused.
// - DAT active set on write command end bit or continue request.
// - DAT active clears on busy release; no busy within 8 SD clocks is not busy.
// - DAT active also clears on busy release after a gap stop.
// - Busy command sets DAT active; its fall raises transfer done if enabled.
// - Write active set on write command end bit or continue request.
// - Write active clears after checksum status of the final block.
// - Write active clears after checksum status of a block stopped at gap.
// - Write active fall by gap stop raises gap event if enabled.
// - Write active reads zero only while no write data is held.
// - Read active set on read command end bit or continue request.
// - Read active clears when the last block reaches the system.
// - Error enable bits 0 to 3 gate command error flags.
// - Error enable bits 4 to 6 gate data error flags.
// - Bit 7 current limit, bit 8 auto command, bit 9 descriptor DMA.
// - Enable zero masks the error flag, one lets it report.
// - Read wait signalling is supported.
`timescale 1ns/1ps
module sd_xfer_status
	import sd_xfer_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	input wire logic SD_CLK,
	input wire logic DAT0_IN,
	output logic DAT2_OUT,
	output logic DAT2_OE,
	output logic SD_CLK_STOP,
	input wire logic WR_CMD_END,
	input wire logic RD_CMD_END,
	input wire logic BUSY_CMD_END,
	input wire logic CRC_STATUS_DONE,
	input wire logic LAST_BLOCK,
	input wire logic RD_BLOCK_DONE,
	input wire logic BUF_FULL,
	input wire logic WR_DATA_HELD,
	input wire logic [9:0] ERR_EVENTS,
	output logic DAT_ACTIVE,
	output logic WR_ACTIVE,
	output logic RD_ACTIVE
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic clk_s1;
		logic clk_s2;
		logic clk_s3;
		logic dat0_s1;
		logic dat0_s2;
		wstate_t wst;
		logic [3:0] wait_cnt;
		logic busy_gap;
		logic wr_act;
		logic wr_rep;
		logic rd_act;
		logic rd_paused;
		logic rd_wait;
		logic clk_stop;
		logic [2:0] gap_ctrl;
		logic [1:0] norm_stat;
		logic [1:0] norm_sten;
		logic [1:0] norm_sigen;
		logic [9:0] err_stat;
		logic [9:0] err_sten;
		logic [9:0] err_sigen;
		logic ack;
		logic [31:0] rdata;
		logic irq;
	} state_t;

	state_t q;
	state_t d;
	logic req;
	logic wr_go;
	logic rd_go;
	logic sd_rise;
	logic cont;
	logic dat_act;
	logic [31:0] wmask;
	logic [31:0] rd_mux;
	logic wr_done;
	logic rd_done;
	logic gap_hit;

	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~q.ack;
	assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		wr_go = AVS_WRITE & q.ack;
		rd_go = AVS_READ & q.ack;
		cont = wr_go && AVS_ADDRESS == OFS_GAP_CTRL && AVS_BYTEENABLE[0]
			&& AVS_WRITEDATA[GC_CONT];
		sd_rise = q.clk_s2 & ~q.clk_s3;
		dat_act = q.wst != W_IDLE || q.rd_act || q.rd_paused;
		// Pin synchronisers
		d.clk_s1 = SD_CLK;
		d.clk_s2 = q.clk_s1;
		d.clk_s3 = q.clk_s2;
		d.dat0_s1 = DAT0_IN;
		d.dat0_s2 = q.dat0_s1;
		// Write and busy tracking
		wr_done = q.wr_act && CRC_STATUS_DONE && (LAST_BLOCK || q.gap_ctrl[GC_STOP]);
		case (q.wst)
			W_IDLE: begin
				if (WR_CMD_END || (cont && q.busy_gap)) begin
					d.wst = W_XFER;
				end else if (BUSY_CMD_END) begin
					d.wst = W_WAIT;
					d.wait_cnt = '0;
				end
			end
			W_XFER: begin
				if (wr_done) begin
					d.wst = W_WAIT;
					d.wait_cnt = '0;
					d.busy_gap = ~LAST_BLOCK;
				end
			end
			W_WAIT: begin
				if (!q.dat0_s2) begin
					d.wst = W_BUSY;
				end else if (sd_rise) begin
					d.wait_cnt = q.wait_cnt + 4'h1;
					if (q.wait_cnt + 4'h1 >= BUSY_WAIT_SDCLK) begin
						d.wst = W_IDLE;
					end
				end
			end
			W_BUSY: begin
				if (q.dat0_s2) begin
					d.wst = W_IDLE;
				end
			end
			default: d.wst = W_IDLE;
		endcase
		if (q.wst == W_IDLE && d.wst == W_XFER) begin
			d.busy_gap = 1'b0;
		end
		if (WR_CMD_END || (cont && q.busy_gap && !q.wr_act)) begin
			d.wr_act = 1'b1;
		end else if (wr_done) begin
			d.wr_act = 1'b0;
		end
		d.wr_rep = d.wr_act | WR_DATA_HELD;
		// Read tracking and stop at gap
		rd_done = q.rd_act && RD_BLOCK_DONE && LAST_BLOCK;
		gap_hit = q.rd_act && RD_BLOCK_DONE && !LAST_BLOCK && q.gap_ctrl[GC_STOP];
		if (RD_CMD_END || (cont && q.rd_paused)) begin
			d.rd_act = 1'b1;
			d.rd_paused = 1'b0;
		end else if (rd_done) begin
			d.rd_act = 1'b0;
		end else if (gap_hit) begin
			d.rd_act = 1'b0;
			d.rd_paused = 1'b1;
		end
		if (q.gap_ctrl[GC_RWAIT_EN]) begin
			d.rd_wait = (d.rd_paused || (BUF_FULL && d.rd_act));
			d.clk_stop = 1'b0;
		end else begin
			d.rd_wait = 1'b0;
			d.clk_stop = d.rd_paused || (BUF_FULL && d.rd_act);
		end
		// Register writes
		if (wr_go) begin
			if (AVS_ADDRESS == OFS_GAP_CTRL) begin
				d.gap_ctrl = (AVS_WRITEDATA[2:0] & wmask[2:0]) | (q.gap_ctrl & ~wmask[2:0]);
				d.gap_ctrl[GC_CONT] = 1'b0;
			end else if (AVS_ADDRESS == OFS_NORM_STEN) begin
				d.norm_sten = (AVS_WRITEDATA[1:0] & wmask[1:0]) | (q.norm_sten & ~wmask[1:0]);
			end else if (AVS_ADDRESS == OFS_NORM_SIGEN) begin
				d.norm_sigen = (AVS_WRITEDATA[1:0] & wmask[1:0]) | (q.norm_sigen & ~wmask[1:0]);
			end else if (AVS_ADDRESS == OFS_ERR_STEN) begin
				d.err_sten = (AVS_WRITEDATA[9:0] & wmask[9:0]) | (q.err_sten & ~wmask[9:0]);
			end else if (AVS_ADDRESS == OFS_ERR_SIGEN) begin
				d.err_sigen = (AVS_WRITEDATA[9:0] & wmask[9:0]) | (q.err_sigen & ~wmask[9:0]);
			end
		end
		if (cont) begin
			d.gap_ctrl[GC_STOP] = 1'b0;
		end
		// Sticky status, read clears, set wins
		if (rd_go && AVS_ADDRESS == OFS_NORM_STAT) begin
			d.norm_stat = '0;
		end
		if (rd_go && AVS_ADDRESS == OFS_ERR_STAT) begin
			d.err_stat = '0;
		end
		if (dat_act && !(d.wst != W_IDLE || d.rd_act || d.rd_paused)
			&& !d.rd_paused && q.norm_sten[NS_XFER_DONE]) begin
			d.norm_stat[NS_XFER_DONE] = 1'b1;
		end
		if (q.norm_sten[NS_GAP_EVT] && ((q.wr_rep && !d.wr_rep && q.gap_ctrl[GC_STOP]
			&& !LAST_BLOCK) || gap_hit)) begin
			d.norm_stat[NS_GAP_EVT] = 1'b1;
		end
		d.err_stat = d.err_stat | (ERR_EVENTS & q.err_sten);
		// Bus answer
		d.ack = req & ~q.ack;
		if (req && !q.ack) begin
			d.rdata = rd_mux;
		end
		d.irq = |(d.norm_stat & q.norm_sigen) || |(d.err_stat & q.err_sigen);
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (AVS_ADDRESS == OFS_PRESENT) begin
			rd_mux[PS_DAT_ACT] = q.wst != W_IDLE || q.rd_act || q.rd_paused;
			rd_mux[PS_WR_ACT] = q.wr_rep;
			rd_mux[PS_RD_ACT] = q.rd_act;
			rd_mux[PS_RD_WAIT] = q.rd_wait;
			rd_mux[PS_CLK_STOP] = q.clk_stop;
		end else if (AVS_ADDRESS == OFS_GAP_CTRL) begin
			rd_mux[2:0] = q.gap_ctrl;
		end else if (AVS_ADDRESS == OFS_NORM_STAT) begin
			rd_mux[1:0] = q.norm_stat;
		end else if (AVS_ADDRESS == OFS_NORM_STEN) begin
			rd_mux[1:0] = q.norm_sten;
		end else if (AVS_ADDRESS == OFS_NORM_SIGEN) begin
			rd_mux[1:0] = q.norm_sigen;
		end else if (AVS_ADDRESS == OFS_ERR_STAT) begin
			rd_mux[9:0] = q.err_stat;
		end else if (AVS_ADDRESS == OFS_ERR_STEN) begin
			rd_mux[9:0] = q.err_sten;
		end else if (AVS_ADDRESS == OFS_ERR_SIGEN) begin
			rd_mux[9:0] = q.err_sigen;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			q <= '0;
			q.clk_s1 <= 1'b0;
			q.dat0_s1 <= 1'b1;
			q.dat0_s2 <= 1'b1;
			q.wst <= W_IDLE;
			q.gap_ctrl <= GAP_CTRL_RST;
			q.norm_sten <= NORM_EN_RST;
			q.norm_sigen <= NORM_EN_RST;
			q.err_sten <= ERR_EN_RST;
			q.err_sigen <= ERR_EN_RST;
		end else begin
			q <= d;
		end
	end

	assign AVS_READDATA = q.rdata;
	assign IRQ = q.irq;
	assign DAT2_OUT = 1'b0;
	assign DAT2_OE = q.rd_wait;
	assign SD_CLK_STOP = q.clk_stop;
	assign DAT_ACTIVE = q.wst != W_IDLE || q.rd_act || q.rd_paused;
	assign WR_ACTIVE = q.wr_rep;
	assign RD_ACTIVE = q.rd_act;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_busy_timeout;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(q.wst == W_WAIT && q.dat0_s2 && sd_rise && q.wait_cnt == 4'h7)
		|=> q.wst == W_IDLE;
	endproperty
	a_busy_timeout: assert property (p_busy_timeout)
		else $error("busy wait did not end after 8 SD clocks");

	property p_busy_release;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(q.wst == W_BUSY && q.dat0_s2) |=> !DAT_ACTIVE || q.rd_act || q.rd_paused;
	endproperty
	a_busy_release: assert property (p_busy_release)
		else $error("DAT active held after busy release");

	property p_wr_set;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		WR_CMD_END |=> q.wr_act ##1 WR_ACTIVE;
	endproperty
	a_wr_set: assert property (p_wr_set)
		else $error("write active not set after command end");

	property p_wr_clear;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(q.wr_act && CRC_STATUS_DONE && LAST_BLOCK && !WR_CMD_END) |=> !q.wr_act;
	endproperty
	a_wr_clear: assert property (p_wr_clear)
		else $error("write active not cleared on last block");

	property p_wr_held;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		$past(WR_DATA_HELD) |-> WR_ACTIVE;
	endproperty
	a_wr_held: assert property (p_wr_held)
		else $error("write active low while data held");

	property p_rd_set;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		RD_CMD_END |=> RD_ACTIVE && DAT_ACTIVE;
	endproperty
	a_rd_set: assert property (p_rd_set)
		else $error("read active not set after command end");

	property p_rd_pause;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(gap_hit && !RD_CMD_END && q.gap_ctrl[GC_RWAIT_EN]) |=> ##1 DAT2_OE && !RD_ACTIVE;
	endproperty
	a_rd_pause: assert property (p_rd_pause)
		else $error("read not paused by read wait at gap");

	property p_mask;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(!$past(q.err_sten[0]) && !$past(q.err_stat[0])) |-> !q.err_stat[0];
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked error flag was set");

	property p_upper_zero;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(AVS_READ && q.ack && AVS_ADDRESS == OFS_ERR_STEN) |-> AVS_READDATA[15:10] == 6'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("reserved enable bits read nonzero");
endmodule : sd_xfer_status

// File: placeholder_unused_never.sv
// Empty compile unit kept free of logic
`timescale 1ns/1ps

// File: sd_card_model.sv
// Card-side model: SD clock within frames and write busy on data line zero
`timescale 1ns/1ps
module sd_card_model (
	input wire logic sys_clk,
	input wire logic run,
	input wire logic start,
	input wire logic [3:0] busy_len,
	output logic sd_clk,
	output logic dat0
);
	logic sd_q = 1'b0;
	logic [3:0] cnt_q = 4'h0;
	// ------
	// Clock toggles only within frames
	// ------
	initial begin
		sd_clk = 1'b0;
		#1.7;
		forever begin
			#16;
			sd_clk = run ? ~sd_clk : 1'b0;
		end
	end
	// ------
	// Busy low for busy_len rises, pulled up after
	// ------
	always @(posedge sys_clk) begin
		sd_q <= sd_clk;
		if (start)
			cnt_q <= busy_len;
		else if (sd_clk && !sd_q && cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	assign dat0 = (cnt_q == 4'h0);
endmodule : sd_card_model

// File: sd_xfer_status_tb.sv
// Self-checking bench of the transfer status block
`timescale 1ns/1ps
module sd_xfer_status_tb_top import sd_xfer_pkg::*;;
	typedef struct {logic [31:0] en; logic [31:0] sig;} row_t;
	logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, dat2_out, dat2_oe;
	logic clk_stop, dat_act, wr_act, rd_act, last_block, buf_full, held, run, start, sd_clk, dat0;
	logic [4:0] avs_address, ev;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	logic [9:0] err_ev;
	logic [3:0] blen;
	logic [6:0] st;
	int bad_count, checked;
	row_t rows[$];
	assign st = {irq, dat2_oe, dat2_out, clk_stop, rd_act, wr_act, dat_act};
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	sd_xfer_status sd_xfer_status_i (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
		.AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .SD_CLK(sd_clk), .DAT0_IN(dat0),
		.DAT2_OUT(dat2_out), .DAT2_OE(dat2_oe), .SD_CLK_STOP(clk_stop), .WR_CMD_END(ev[0]),
		.RD_CMD_END(ev[1]), .BUSY_CMD_END(ev[2]), .CRC_STATUS_DONE(ev[3]),
		.LAST_BLOCK(last_block), .RD_BLOCK_DONE(ev[4]), .BUF_FULL(buf_full),
		.WR_DATA_HELD(held), .ERR_EVENTS(err_ev), .DAT_ACTIVE(dat_act), .WR_ACTIVE(wr_act),
		.RD_ACTIVE(rd_act));
	sd_card_model sd_card_model_i (.sys_clk(sys_clk), .run(run & ~clk_stop), .start(start),
		.busy_len(blen), .sd_clk(sd_clk), .dat0(dat0));
	// ------
	// Shared tasks
	// ------
	task automatic stop_test;
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_st(input logic [6:0] exp, input logic [6:0] m);
		chk({25'h0, st & m}, {25'h0, exp});
	endtask : chk_st
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge sys_clk);
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask : rd
	task automatic pulse(input logic [4:0] e);
		ev <= e;
		@(posedge sys_clk);
		ev <= 5'h00;
		repeat (3) @(posedge sys_clk);
	endtask : pulse
	task automatic finish_busy(input logic [3:0] b);
		int n;
		n = 0;
		blen <= b;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		repeat (36) @(posedge sys_clk);
		chk_st(7'h01, 7'h7F);
		while (dat_act !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (3) @(posedge sys_clk);
		chk_st(7'h40, 7'h7F);
		rd(OFS_NORM_STAT, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk_st(7'h00, 7'h7F);
	endtask : finish_busy
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		stop_test();
	end
	// ------
	// Table of error enable cases, then transfers
	// ------
	initial begin
		{sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 39'h0};
		{ev, err_ev, last_block, buf_full, held, run, start, blen} = 24'h0;
		rows = '{'{32'hFFFF_FFFF, 32'h3FF}, '{32'hFFFF_FC00, 32'h3FF}, '{32'h3FF, 32'h0},
			'{32'h155, 32'h2AA}, '{32'h2AA, 32'h2AA}};
		for (int i = 0; i < 10; i++)
			rows.push_back('{32'h1 << i, 32'h1 << i});
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(OFS_PRESENT, 32'h0);
		rd(OFS_ERR_STEN, {22'h0, ERR_EN_RST});
		rd(5'h02, 32'h0);
		foreach (rows[i]) begin
			bus(1'b1, OFS_ERR_SIGEN, rows[i].sig);
			bus(1'b1, OFS_ERR_STEN, rows[i].en);
			rd(OFS_ERR_STEN, rows[i].en & 32'h3FF);
			err_ev <= 10'h3FF;
			@(posedge sys_clk);
			err_ev <= 10'h000;
			repeat (3) @(posedge sys_clk);
			chk_st({|(rows[i].en & rows[i].sig & 32'h3FF), 6'h00}, 7'h7F);
			rd(OFS_ERR_STAT, rows[i].en & 32'h3FF);
			repeat (3) @(posedge sys_clk);
			chk_st(7'h00, 7'h7F);
		end
		bus(1'b1, OFS_NORM_STEN, 32'h3);
		bus(1'b1, OFS_NORM_SIGEN, 32'h3);
		run <= 1'b1;
		held <= 1'b1;
		last_block <= 1'b1;
		pulse(5'h01);
		rd(OFS_PRESENT, 32'h3);
		pulse(5'h08);
		chk_st(7'h03, 7'h7F);
		held <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_st(7'h01, 7'h7F);
		finish_busy(4'h8);
		pulse(5'h01);
		pulse(5'h08);
		finish_busy(4'h0);
		pulse(5'h04);
		finish_busy(4'h8);
		bus(1'b1, OFS_GAP_CTRL, 32'h1);
		last_block <= 1'b0;
		pulse(5'h01);
		pulse(5'h08);
		chk_st(7'h41, 7'h7F);
		blen <= 4'h8;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		repeat (36) @(posedge sys_clk);
		chk_st(7'h41, 7'h7F);
		while (dat_act !== 1'b0) begin
			@(posedge sys_clk);
		end
		rd(OFS_PRESENT, 32'h0);
		bus(1'b0, OFS_NORM_STAT, 32'h0);
		chk(rdata & 32'h2, 32'h2);
		bus(1'b1, OFS_GAP_CTRL, 32'h2);
		repeat (3) @(posedge sys_clk);
		chk_st(7'h03, 7'h7F);
		last_block <= 1'b1;
		pulse(5'h08);
		finish_busy(4'h8);
		bus(1'b1, OFS_GAP_CTRL, 32'h4);
		pulse(5'h02);
		chk_st(7'h04, 7'h7E);
		buf_full <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk_st(7'h24, 7'h3E);
		bus(1'b1, OFS_GAP_CTRL, 32'h5);
		last_block <= 1'b0;
		pulse(5'h10);
		buf_full <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_st(7'h20, 7'h3E);
		bus(1'b1, OFS_GAP_CTRL, 32'h6);
		repeat (3) @(posedge sys_clk);
		chk_st(7'h04, 7'h3E);
		last_block <= 1'b1;
		pulse(5'h10);
		chk_st(7'h00, 7'h3E);
		bus(1'b1, OFS_GAP_CTRL, 32'h1);
		last_block <= 1'b0;
		pulse(5'h02);
		pulse(5'h10);
		chk_st(7'h08, 7'h3E);
		bus(1'b1, OFS_GAP_CTRL, 32'h2);
		repeat (3) @(posedge sys_clk);
		chk_st(7'h04, 7'h3E);
		// ------
		// Reset in mid-run
		// ------
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk_st(7'h00, 7'h7F);
		sys_rst <= 1'b0;
		rd(OFS_PRESENT, 32'h0);
		rd(OFS_GAP_CTRL, {29'h0, GAP_CTRL_RST});
		rd(OFS_ERR_SIGEN, {22'h0, ERR_EN_RST});
		rd(OFS_ERR_STEN, {22'h0, ERR_EN_RST});
		stop_test();
	end
endmodule : sd_xfer_status_tb_top
